// [rtl/fpec_pkg.sv]
// package for the program and erase command sequencer
// Notes on behaviour
// - 12h always takes a 32-bit address
// - 32h programs up to 256 bytes, quad
// - quad program needs write enable latch set
// - quad program otherwise equals page program
// - 34h always takes a 32-bit address
// - 20h erases a 4 KB sector
// - erases need write enable latch set
// - chip select rises on byte boundary, else discard
// - chip select rise starts self-timed busy cycle
// - erase completion clears write enable latch
// - protected targets are never erased
// - 21h always takes a 32-bit address
// - 52h erases a 32 KB block
// - d8h erases a 64 KB block
// - 4-byte mode widens plain opcodes' address
// - program address wraps inside 256-byte page
// - program completion clears latch, busy meanwhile
package fpec_pkg;
	localparam logic [7:0] OP_PROG = 8'h02;
	localparam logic [7:0] OP_PROG4 = 8'h12;
	localparam logic [7:0] OP_QPROG = 8'h32;
	localparam logic [7:0] OP_QPROG4 = 8'h34;
	localparam logic [7:0] OP_SE = 8'h20;
	localparam logic [7:0] OP_SE4 = 8'h21;
	localparam logic [7:0] OP_BE32 = 8'h52;
	localparam logic [7:0] OP_BE64 = 8'hd8;
	localparam logic [5:0] ADDR_BITS_3B = 6'h18;
	localparam logic [5:0] ADDR_BITS_4B = 6'h20;
	localparam logic [3:0] OPC_BITS = 4'h8;
	localparam logic [9:0] BLOCKS_TOTAL = 10'h200;
	localparam int CORE_MHZ = 50;
	localparam int PROG_TIME_US = 400;
	localparam int SECTOR_ERASE_TIME_US = 45000;
	localparam int SMALL_BLOCK_ERASE_TIME_US = 120000;
	localparam int LARGE_BLOCK_ERASE_TIME_US = 150000;
	localparam int PROG_CYC = PROG_TIME_US * CORE_MHZ;
	localparam int SE_CYC = SECTOR_ERASE_TIME_US * CORE_MHZ;
	localparam int BE32_CYC = SMALL_BLOCK_ERASE_TIME_US * CORE_MHZ;
	localparam int BE64_CYC = LARGE_BLOCK_ERASE_TIME_US * CORE_MHZ;
	typedef enum logic [2:0] {K_NONE, K_PROG, K_SE, K_BE32, K_BE64} fpec_kind_t;
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic [3:0] io;
	} fpec_pins_t;
	typedef struct packed {
		logic protect_complement;
		logic protect_top_bottom;
		logic [3:0] level;
	} fpec_prot_t;
	typedef struct packed {
		logic valid;
		fpec_kind_t kind;
		logic [31:0] addr;
	} fpec_cmd_t;
	typedef struct packed {
		logic valid;
		logic [7:0] idx;
		logic [7:0] data;
	} fpec_wr_t;
endpackage

// [rtl/fpec_core.sv]
// program and erase command sequencer for one flash die
`timescale 1ns/1ns
module fpec_core #(
	parameter int PROG_CYCLES = fpec_pkg::PROG_CYC,
	parameter int SE_CYCLES = fpec_pkg::SE_CYC,
	parameter int BE32_CYCLES = fpec_pkg::BE32_CYC,
	parameter int BE64_CYCLES = fpec_pkg::BE64_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire fpec_pkg::fpec_pins_t i_pins,
	input wire logic i_addr4_mode,
	input wire logic i_wel_set,
	input wire logic i_wel_clr,
	input wire fpec_pkg::fpec_prot_t i_prot,
	input wire logic i_lock_hit,
	output logic o_busy,
	output logic o_write_enable_latch,
	output logic [31:0] o_target_addr,
	output fpec_pkg::fpec_cmd_t o_cmd,
	output fpec_pkg::fpec_wr_t o_wr
);
	import fpec_pkg::*;

	typedef enum logic [2:0] {S_IDLE, S_OPC, S_ADDR, S_DATA, S_DONE, S_SKIP} fpec_state_t;

	// ==========================================
	// decoding
	function automatic fpec_kind_t op_kind(input logic [7:0] op);
		unique case (op)
			OP_PROG, OP_PROG4, OP_QPROG, OP_QPROG4: op_kind = K_PROG;
			OP_SE, OP_SE4: op_kind = K_SE;
			OP_BE32: op_kind = K_BE32;
			OP_BE64: op_kind = K_BE64;
			default: op_kind = K_NONE;
		endcase
	endfunction

	function automatic logic op_force4(input logic [7:0] op);
		op_force4 = (op == OP_PROG4) || (op == OP_QPROG4) || (op == OP_SE4);
	endfunction

	function automatic logic is_protected(input fpec_prot_t p, input logic [31:0] a);
		logic [9:0] n;
		logic [9:0] blk;
		logic hit;
		n = (p.level == 4'h0) ? 10'h000 : (p.level >= 4'ha) ? BLOCKS_TOTAL : 10'(10'h001 << (p.level - 4'h1));
		blk = {1'b0, a[24:16]};
		hit = p.protect_top_bottom ? (blk < n) : (blk >= BLOCKS_TOTAL - n);
		is_protected = hit ^ p.protect_complement;
	endfunction

	// ==========================================
	// pin synchronisers
	fpec_pins_t s1_q, s2_q, s3_q;
	always_ff @(posedge i_core_clk)
	begin
		s1_q <= i_pins;
		s2_q <= s1_q;
		s3_q <= s2_q;
	end
	wire sclk_rise = s2_q.sclk & ~s3_q.sclk & ~s2_q.cs_n;
	wire cs_fall = ~s2_q.cs_n & s3_q.cs_n;
	wire cs_rise = s2_q.cs_n & ~s3_q.cs_n;

	// ==========================================
	// frame shifter
	fpec_state_t st_q;
	logic [7:0] op_q;
	logic [5:0] cnt_q;
	logic [5:0] addr_need_q;
	logic [31:0] addr_q;
	logic [7:0] sh_q;
	logic [7:0] idx_q;
	logic got_byte_q;
	logic quad_q;
	wire [7:0] op_next = {op_q[6:0], s2_q.io[0]};
	wire [7:0] sh_next = quad_q ? {sh_q[3:0], s2_q.io} : {sh_q[6:0], s2_q.io[0]};
	wire [5:0] byte_clks = quad_q ? 6'h02 : 6'h08;

	always_ff @(posedge i_core_clk)
	begin
		if (i_srst || cs_fall || s2_q.cs_n)
		begin
			st_q <= s2_q.cs_n ? S_IDLE : S_OPC;
			cnt_q <= 6'h00;
			got_byte_q <= 1'b0;
			o_wr <= '0;
			if (i_srst)
				addr_q <= 32'h0000_0000;
		end
		else
		begin
			o_wr.valid <= 1'b0;
			if (sclk_rise)
			begin
				unique case (st_q)
					S_OPC:
					begin
						op_q <= op_next;
						cnt_q <= cnt_q + 6'h01;
						if (cnt_q == 6'(OPC_BITS - 4'h1))
						begin
							cnt_q <= 6'h00;
							quad_q <= (op_next == OP_QPROG) || (op_next == OP_QPROG4);
							addr_need_q <= (op_force4(op_next) || i_addr4_mode) ? ADDR_BITS_4B : ADDR_BITS_3B;
							st_q <= (op_kind(op_next) == K_NONE || o_busy) ? S_SKIP : S_ADDR;
						end
					end
					S_ADDR:
					begin
						addr_q <= {addr_q[30:0], s2_q.io[0]};
						cnt_q <= cnt_q + 6'h01;
						if (cnt_q == addr_need_q - 6'h01)
						begin
							cnt_q <= 6'h00;
							if (addr_need_q == ADDR_BITS_3B)
								addr_q <= {8'h00, addr_q[22:0], s2_q.io[0]};
							idx_q <= {addr_q[6:0], s2_q.io[0]};
							st_q <= (op_kind(op_q) == K_PROG) ? S_DATA : S_DONE;
						end
					end
					S_DATA:
					begin
						sh_q <= sh_next;
						cnt_q <= cnt_q + 6'h01;
						if (cnt_q == byte_clks - 6'h01)
						begin
							cnt_q <= 6'h00;
							got_byte_q <= 1'b1;
							o_wr <= '{valid: 1'b1, idx: idx_q, data: sh_next};
							idx_q <= idx_q + 8'h01;
						end
					end
					S_DONE: st_q <= S_SKIP;
					default: st_q <= S_SKIP;
				endcase
			end
		end
	end

	// ==========================================
	// commit check on chip select rise
	fpec_kind_t kind_w;
	logic frame_ok;
	logic prot_hit;
	always_comb
	begin
		kind_w = op_kind(op_q);
		frame_ok = (st_q == S_DONE) || (st_q == S_DATA && cnt_q == 6'h00 && got_byte_q);
		prot_hit = is_protected(i_prot, addr_q) || i_lock_hit;
	end
	wire start = cs_rise && frame_ok && o_write_enable_latch && !o_busy && !prot_hit;

	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
			o_target_addr <= 32'h0000_0000;
		else
			o_target_addr <= addr_q;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
			o_cmd <= '0;
		else
		begin
			o_cmd.valid <= start;
			if (start)
			begin
				o_cmd.kind <= kind_w;
				unique case (kind_w)
					K_SE: o_cmd.addr <= {addr_q[31:12], 12'h000};
					K_BE32: o_cmd.addr <= {addr_q[31:15], 15'h0000};
					K_BE64: o_cmd.addr <= {addr_q[31:16], 16'h0000};
					default: o_cmd.addr <= {addr_q[31:8], 8'h00};
				endcase
			end
		end
	end

	// ==========================================
	// self-timed busy cycle
	logic [31:0] busy_cnt_q;
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
		begin
			o_busy <= 1'b0;
			busy_cnt_q <= 32'h0000_0000;
		end
		else if (start)
		begin
			o_busy <= 1'b1;
			unique case (kind_w)
				K_SE: busy_cnt_q <= 32'(SE_CYCLES);
				K_BE32: busy_cnt_q <= 32'(BE32_CYCLES);
				K_BE64: busy_cnt_q <= 32'(BE64_CYCLES);
				default: busy_cnt_q <= 32'(PROG_CYCLES);
			endcase
		end
		else if (o_busy)
		begin
			busy_cnt_q <= busy_cnt_q - 32'h0000_0001;
			if (busy_cnt_q <= 32'h0000_0001)
				o_busy <= 1'b0;
		end
	end
	wire done = o_busy && busy_cnt_q <= 32'h0000_0001;

	// ==========================================
	// write enable latch, set wins over clear
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
			o_write_enable_latch <= 1'b0;
		else if (i_wel_set)
			o_write_enable_latch <= 1'b1;
		else if (done || i_wel_clr)
			o_write_enable_latch <= 1'b0;
	end

	// ==========================================
	// checks
	start_busy_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
		start |=> o_busy && o_cmd.valid) else $error("busy not raised after start");
	busy_hold_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
		o_busy && busy_cnt_q > 32'h0000_0001 |=> o_busy) else $error("busy dropped early");
	wel_clear_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
		$fell(o_busy) && !$past(i_wel_set) |-> !o_write_enable_latch) else $error("latch kept after cycle");
	wel_needed_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
		o_cmd.valid |-> $past(o_write_enable_latch)) else $error("command without latch");
	busy_ignore_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
		o_cmd.valid |-> !$past(o_busy)) else $error("command accepted while busy");
	protect_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
		o_cmd.valid |-> !$past(prot_hit)) else $error("protected target executed");
	four_byte_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
		st_q == S_ADDR && op_force4(op_q) |-> addr_need_q == ADDR_BITS_4B) else $error("short address");
	mode_len_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
		sclk_rise && st_q == S_OPC && cnt_q == 6'h07 && i_addr4_mode ##1 st_q == S_ADDR
		|-> addr_need_q == ADDR_BITS_4B) else $error("mode ignored");
	frame_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
		o_cmd.valid |-> $past(st_q) == S_DONE || $past(st_q) == S_DATA && $past(cnt_q) == 6'h00)
		else $error("bad framing accepted");
	sector_align_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
		o_cmd.valid && o_cmd.kind == K_SE |-> o_cmd.addr[11:0] == 12'h000) else $error("sector misaligned");
	prog_c: cover property (@(posedge i_core_clk) disable iff (i_srst) o_cmd.valid && o_cmd.kind == K_PROG);
	quad_c: cover property (@(posedge i_core_clk) disable iff (i_srst) o_wr.valid && quad_q);
	erase_c: cover property (@(posedge i_core_clk) disable iff (i_srst) o_cmd.valid && o_cmd.kind == K_BE64);
	done_c: cover property (@(posedge i_core_clk) disable iff (i_srst) $fell(o_busy));
endmodule

// [tb/fpec_host.sv]
// host controller model that frames commands on the serial pins
`timescale 1ns/1ns
module fpec_host (
	output fpec_pkg::fpec_pins_t o_pins
);
	import fpec_pkg::*;
	initial o_pins = 6'h20;
	// ==========
	// serial clocking, sclk stands low between frames
	task automatic shift(input logic [31:0] v, input int n, input bit q);
		for (int i = n - 1; i >= 0; i -= q ? 4 : 1)
		begin
			o_pins.io = q ? v[i-:4] : {~o_pins.io[3:1], v[i]};
			#80 o_pins.sclk = 1'b1;
			#80 o_pins.sclk = 1'b0;
		end
	endtask
	task automatic frame(input logic [7:0] op, input logic [31:0] a, input int na, input logic [31:0] d,
		input int nd, input bit q);
		o_pins.cs_n = 1'b0;
		#80 shift({24'h0, op}, 8, 1'b0);
		shift(a, na, 1'b0);
		shift(d, nd, q);
		#80 o_pins.cs_n = 1'b1;
		o_pins.io = ~o_pins.io;
		#320;
	endtask
endmodule

// [tb/fpec_core_bench.sv]
// self-checking bench for the program and erase sequencer
`timescale 1ns/1ns
module fpec_core_bench;
	import fpec_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic a4 = 1'b0;
	logic wset = 1'b0;
	logic wclr = 1'b0;
	logic lock = 1'b0;
	fpec_prot_t prot = '0;
	fpec_pins_t pins;
	logic busy, write_enable_latch;
	logic [31:0] taddr;
	fpec_cmd_t cmd, got;
	fpec_wr_t wr, last;
	int miscompares = 0;
	int checks_done = 0;
	int cmd_n = 0;
	int busy_n = 0;
	int wr_n = 0;
	int w0;
	fpec_host u_fpec_host (.o_pins(pins));
	fpec_core #(.PROG_CYCLES(20), .SE_CYCLES(24), .BE32_CYCLES(28), .BE64_CYCLES(700)) u_fpec_core (
		.i_core_clk(clk),
		.i_srst(srst),
		.i_pins(pins),
		.i_addr4_mode(a4),
		.i_wel_set(wset),
		.i_wel_clr(wclr),
		.i_prot(prot),
		.i_lock_hit(lock),
		.o_busy(busy),
		.o_write_enable_latch(write_enable_latch),
		.o_target_addr(taddr),
		.o_cmd(cmd),
		.o_wr(wr)
	);
	initial forever #10 clk = ~clk;
	// ==========
	// monitor
	always @(posedge clk)
	begin
		if (cmd.valid)
			got <= cmd;
		if (wr.valid)
			last <= wr;
		cmd_n <= cmd_n + cmd.valid;
		busy_n <= busy_n + busy;
		wr_n <= wr_n + wr.valid;
	end
	// ==========
	// tasks
	task automatic conclude;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cmp(input logic [63:0] g, input logic [63:0] e);
		checks_done++;
		if (g !== e)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic run(input bit s, input logic [7:0] op, input logic [31:0] a, input int na,
		input logic [31:0] d, input int nd, input bit q, input int cyc, input fpec_kind_t k,
		input logic [31:0] ea, input logic we);
		int c0, b0, n;
		if (s)
		begin
			wset = 1'b1;
			tick(1);
			wset = 1'b0;
		end
		c0 = cmd_n;
		b0 = busy_n;
		w0 = wr_n;
		u_fpec_host.frame(op, a, na, d, nd, q);
		n = 0;
		while (busy === 1'b1 && n < 1000)
		begin
			tick(1);
			n++;
		end
		if (n == 1000)
		begin
			miscompares++;
			conclude();
		end
		cmp(cmd_n - c0, cyc > 0);
		if (cyc >= 0)
			cmp(busy_n - b0, cyc);
		if (cyc > 0)
			cmp({got.kind, got.addr}, {k, ea});
		cmp(write_enable_latch, we);
	endtask
	// ==========
	// scenarios
	initial
	begin
		tick(16);
		srst = 1'b0;
		tick(3);
		cmp({busy, write_enable_latch, taddr}, 0);
		run(0, 8'h20, 32'habcdef, 24, 0, 0, 0, 0, K_NONE, 0, 0);
		run(1, 8'h20, 32'habcdef, 24, 0, 0, 0, 24, K_SE, 32'habc000, 0);
		run(1, 8'h52, 32'habcdef, 24, 0, 0, 0, 28, K_BE32, 32'hab8000, 0);
		run(1, 8'h21, 32'h01abcdef, 32, 0, 0, 0, 24, K_SE, 32'h01abc000, 0);
		cmp(taddr, 32'h01abcdef);
		a4 = 1'b1;
		run(1, 8'h20, 32'h01abcdef, 32, 0, 0, 0, 24, K_SE, 32'h01abc000, 0);
		a4 = 1'b0;
		run(1, 8'h20, 0, 25, 0, 0, 0, 0, K_NONE, 0, 1);
		run(0, 8'h20, 0, 16, 0, 0, 0, 0, K_NONE, 0, 1);
		prot.level = 4'ha;
		run(0, 8'h52, 0, 24, 0, 0, 0, 0, K_NONE, 0, 1);
		prot = '0;
		lock = 1'b1;
		run(0, 8'hd8, 0, 24, 0, 0, 0, 0, K_NONE, 0, 1);
		lock = 1'b0;
		prot = 6'h20;
		run(0, 8'h20, 32'h10000, 24, 0, 0, 0, 0, K_NONE, 0, 1);
		prot = 6'h11;
		run(0, 8'h20, 0, 24, 0, 0, 0, 0, K_NONE, 0, 1);
		prot = '0;
		run(0, 8'h20, 0, 24, 0, 8, 0, 0, K_NONE, 0, 1);
		wclr = 1'b1;
		tick(1);
		wclr = 1'b0;
		run(0, 8'h32, 0, 24, 8'h5a, 8, 1, 0, K_NONE, 0, 0);
		run(1, 8'h02, 32'hfe, 24, 32'h112233, 24, 0, 20, K_PROG, 0, 0);
		cmp({wr_n - w0, last.idx, last.data}, {16'h3, 16'h0033});
		run(1, 8'h34, 32'h01000010, 32, 32'ha55a, 16, 1, 20, K_PROG, 32'h01000000, 0);
		cmp({wr_n - w0, last.idx, last.data}, {16'h2, 16'h115a});
		run(1, 8'h32, 32'h0305, 24, 32'h7e, 8, 1, 20, K_PROG, 32'h0300, 0);
		cmp({last.idx, last.data}, 16'h057e);
		run(1, 8'h12, 32'h0200, 32, 32'hc3, 8, 0, 20, K_PROG, 32'h0200, 0);
		run(1, 8'h32, 0, 24, 32'h7, 4, 1, 0, K_NONE, 0, 1);
		u_fpec_host.frame(8'hd8, 32'h12ffff, 24, 0, 0, 1'b0);
		run(0, 8'h20, 0, 24, 0, 0, 0, -1, K_NONE, 0, 0);
		cmp({got.kind, got.addr}, {K_BE64, 32'h120000});
		conclude();
	end
endmodule
